/* core/kms_keypad.sv */
// kms_keypad: keypad matrix scanner with Wishbone register slave and key-detect interrupt
//
// Notes on behaviour
// - Status register shows the present keypad clock level, read only.
// - Scan enable set: automatic scanning; clear: firmware drives and senses matrix.
// - Scan mode: debounced press sets flag and latches column and row.
// - Bypass: row falling edge after all rows high sets flag; bounce repeats it.
// - Reading the control/status register clears the key-detect flag.
// - Bypass edge detection works with the keypad clock stopped.
// - Detect enable gates only the interrupt; the flag still sets.
// - Size register matters only while hardware scanning is enabled.
// - Row count field at size bits 5:3, up to 6 rows.
// - Column count field at size bits 2:0, up to 5 columns.
// - Five 3-bit column order slots spread over low and high order registers.
// - Scan visits slots first to last up to column count, driving slot's column.
// - Shared register keypad flag follows key-detect setting; its read clears it.
// - Shared register bit 1 enables the keypad interrupt.
// - Shared register clock flag at bit 4 clears on read; enable at bit 5.
// - Press and release debounced in 4 ms steps; zero means 256 ms.
// - Two-bit scan interval in ms between successive key checks.
// - Columns active low; scan check drives only selected column low, waiting and release drive all low; all ones leaves all high.
// - Row register bit-mapped to row pins; low means pressed.
//
// Chosen here: the Wishbone interface to the registers.
`default_nettype none

module kms_keypad
    import kms_pkg::*;
#(
    parameter int unsigned KEY_HALF = KEY_HALF_CYCLES   // core cycles per half keypad clock
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [17:2] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic [5:0]  row_i,
    output logic      [4:0]  col_o,
    input  wire logic        key_clock_enable_i,
    input  wire logic        clock_event_i,
    output logic             keypad_irq_o,
    output logic             clock_irq_o
);

    typedef struct packed {
        kms_state_t st;
        logic [4:0] col_drv;
        logic [4:0] col_reg;
        logic [5:0] row_hold;
        logic [5:0] row_prev;
        logic [7:0] scan_reg;
        logic [5:0] size_reg;
        logic [7:0] ord_lo;
        logic [6:0] ord_hi;
        logic       kd_en;
        logic       key_det;
        logic       hw_en;
        logic       kp_flag;
        logic       kp_en;
        logic       clk_flag;
        logic       clk_en;
        logic [2:0] slot;
        logic [8:0] ms_cnt;
        logic       ack;
        logic [7:0] rdat;
        logic       irq;
        logic       clk_irq;
    } kms_regs_t;

    kms_regs_t q;
    kms_regs_t n;

    logic        ms_tick;
    logic        clk_level;
    logic        req;
    logic        wr;
    logic        rd_cs;
    logic        rd_si;
    logic [15:0] idx;
    logic [2:0]  row_cnt;
    logic [2:0]  col_lim;
    logic [6:0]  row_one;
    logic [5:0]  row_mask;
    logic [5:0]  rows_masked;
    logic        rows_any;
    logic [14:0] order;
    logic [8:0]  db_ms;
    logic [8:0]  scan_ms;
    logic [8:0]  cnt_inc;
    logic        det_bypass;
    logic        found;
    logic        det_set;
    logic [7:0]  rd_val;

    // ------------------------------------------------------------------
    // keypad clock; stopping it stalls only the scanner
    // ------------------------------------------------------------------
    kms_tick #(
        .HALF_CYCLES (KEY_HALF)
    ) u_tick (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   (key_clock_enable_i),
        .level_o (clk_level),
        .tick_o  (ms_tick)
    );

    // column drive pattern of one order slot; a slot above 4 drives nothing
    function automatic logic [4:0] slot_drive(input logic [14:0] ord, input logic [2:0] s);
        logic [2:0] c;
        c = ord[3*s +: 3];
        slot_drive = (c < 3'(NUM_COLS)) ? ~(5'h01 << c) : COLS_IDLE;
    endfunction

    // ------------------------------------------------------------------
    // bus decode; ack gates req so each access is taken once
    // ------------------------------------------------------------------
    assign req   = cyc_i & stb_i & ~q.ack;
    assign idx   = adr_i;
    assign wr    = req & we_i & sel_i[0];
    assign rd_cs = req & ~we_i & (idx == IDX_CTRL_STATUS);
    assign rd_si = req & ~we_i & (idx == IDX_SHARED_IRQ);

    // size fields; 0 or out-of-range counts fall back to the full matrix
    assign row_cnt     = q.size_reg[SIZE_ROW_LSB +: 3];
    assign col_lim     = (q.size_reg[SIZE_COL_LSB +: 3] == 3'h0 ||
                          q.size_reg[SIZE_COL_LSB +: 3] > 3'(NUM_COLS)) ?
                         3'(NUM_COLS) : q.size_reg[SIZE_COL_LSB +: 3];
    assign row_one     = 7'h01 << row_cnt;
    assign row_mask    = (row_cnt == 3'h0 || row_cnt > 3'(NUM_ROWS)) ?
                         ROWS_IDLE : 6'(row_one - 7'h01);
    assign rows_masked = row_i | ~row_mask;
    assign rows_any    = ~&rows_masked;
    assign order       = {q.ord_hi, q.ord_lo};

    // timer targets in milliseconds
    assign db_ms   = (q.scan_reg[DB_LSB +: 6] == 6'h00) ? DEBOUNCE_ZERO_MS :
                     9'({3'h0, q.scan_reg[DB_LSB +: 6]} * DEBOUNCE_STEP_MS);
    assign scan_ms = (q.scan_reg[SC_LSB +: 2] == 2'h0) ? SCAN_ZERO_MS :
                     {7'h00, q.scan_reg[SC_LSB +: 2]};
    assign cnt_inc = 9'(q.ms_cnt + 9'h001);

    // bypass edge detect runs on the core clock alone
    assign det_bypass = ~q.hw_en & (&q.row_prev) & ~(&row_i);
    assign det_set    = det_bypass | found;

    // ------------------------------------------------------------------
    // read mux; reserved bits read as zero
    // ------------------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        case (idx)
            IDX_COL_DRIVE:   rd_val = {3'h0, q.col_reg};
            IDX_ROW_SENSE:   rd_val = {2'h0, (q.hw_en ? q.row_hold : q.row_prev)};
            IDX_SCAN_TIMING: rd_val = q.scan_reg;
            IDX_CTRL_STATUS: rd_val = {4'h0, clk_level, q.hw_en, q.key_det, q.kd_en};
            IDX_SIZE:        rd_val = {2'h0, q.size_reg};
            IDX_ORDER_LOW:   rd_val = q.ord_lo;
            IDX_ORDER_HIGH:  rd_val = {1'b0, q.ord_hi};
            IDX_SHARED_IRQ:  rd_val = {2'h0, q.clk_en, q.clk_flag, 2'h0, q.kp_en, q.kp_flag};
            default:         rd_val = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // next state: bus writes, scanner, flags, outputs
    // ------------------------------------------------------------------
    always_comb begin
        n          = q;
        found      = 1'b0;
        n.ack      = req;
        n.rdat     = (req & ~we_i) ? rd_val : 8'h00;
        n.row_prev = row_i;
        // register writes take lane 0 only
        if (wr) begin
            case (idx)
                IDX_COL_DRIVE:   n.col_reg  = dat_i[4:0];
                IDX_SCAN_TIMING: n.scan_reg = dat_i[7:0];
                IDX_CTRL_STATUS: begin
                    n.kd_en = dat_i[CS_KD_EN];
                    n.hw_en = dat_i[CS_HW_EN];
                end
                IDX_SIZE:        n.size_reg = dat_i[5:0];
                IDX_ORDER_LOW:   n.ord_lo   = dat_i[7:0];
                IDX_ORDER_HIGH:  n.ord_hi   = dat_i[6:0];
                IDX_SHARED_IRQ: begin
                    n.kp_en  = dat_i[SI_KP_EN];
                    n.clk_en = dat_i[SI_CLK_EN];
                end
                default: ;
            endcase
        end
        // bypass: firmware owns the columns, size and order are ignored
        if (!q.hw_en) begin
            n.st      = KMS_IDLE;
            n.col_drv = q.col_reg;
            n.ms_cnt  = 9'h000;
            n.slot    = 3'h0;
        end else begin
            case (q.st)
                KMS_IDLE: begin
                    n.col_drv = COLS_ALL_LOW;
                    n.ms_cnt  = 9'h000;
                    if (rows_any) begin
                        n.st = KMS_PRESS;
                    end
                end
                KMS_PRESS: begin
                    // a press must stay for the whole debounce time
                    if (!rows_any) begin
                        n.st = KMS_IDLE;
                    end else if (ms_tick) begin
                        if (cnt_inc >= db_ms) begin
                            n.st      = KMS_SCAN;
                            n.ms_cnt  = 9'h000;
                            n.slot    = 3'h0;
                            n.col_drv = slot_drive(order, 3'h0);
                        end else begin
                            n.ms_cnt = cnt_inc;
                        end
                    end
                end
                KMS_SCAN: begin
                    if (ms_tick) begin
                        if (cnt_inc >= scan_ms) begin
                            n.ms_cnt = 9'h000;
                            if (rows_any) begin
                                found      = 1'b1;
                                n.col_reg  = q.col_drv;
                                n.row_hold = rows_masked;
                                n.st       = KMS_RELEASE;
                                n.col_drv  = COLS_ALL_LOW;
                            end else if (3'(q.slot + 3'h1) >= col_lim) begin
                                n.st      = KMS_IDLE;
                                n.col_drv = COLS_ALL_LOW;
                            end else begin
                                n.slot    = 3'(q.slot + 3'h1);
                                n.col_drv = slot_drive(order, 3'(q.slot + 3'h1));
                            end
                        end else begin
                            n.ms_cnt = cnt_inc;
                        end
                    end
                end
                KMS_RELEASE: begin
                    // release is debounced too, so one press reports once
                    n.col_drv = COLS_ALL_LOW;
                    if (rows_any) begin
                        n.ms_cnt = 9'h000;
                    end else if (ms_tick) begin
                        if (cnt_inc >= db_ms) begin
                            n.st = KMS_IDLE;
                        end else begin
                            n.ms_cnt = cnt_inc;
                        end
                    end
                end
                default: n.st = KMS_IDLE;
            endcase
        end
        // flags: a detection in the clearing cycle wins over the read
        if (rd_cs) begin
            n.key_det = 1'b0;
        end
        if (rd_si) begin
            n.kp_flag  = 1'b0;
            n.clk_flag = 1'b0;
        end
        if (det_bypass || found) begin
            n.key_det = 1'b1;
            n.kp_flag = 1'b1;
        end
        if (clock_event_i) begin
            n.clk_flag = 1'b1;
        end
        n.irq     = q.kp_flag & q.kd_en & q.kp_en;
        n.clk_irq = q.clk_flag & q.clk_en;
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q          <= '0;
            q.col_drv  <= COLS_IDLE;
            q.col_reg  <= RST_COL_DRIVE;
            q.row_hold <= ROWS_IDLE;
            q.row_prev <= ROWS_IDLE;
            q.scan_reg <= RST_REG8;
        end else begin
            q <= n;
        end
    end

    assign dat_o        = {24'h000000, q.rdat};
    assign ack_o        = q.ack;
    assign col_o        = q.col_drv;
    assign keypad_irq_o = q.irq;
    assign clock_irq_o  = q.clk_irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_READ_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_cs && !det_set) |=> (!q.key_det && $stable(q.kp_flag)))
        else $error("status read did not clear key detect");
    AST_FLAG_NO_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i)
        (det_set && !q.kd_en && !n.kd_en) |=> (q.key_det && q.kp_flag) ##1 !keypad_irq_o)
        else $error("key detect not set while interrupt disabled");
    AST_BYPASS_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        (!q.hw_en && (&q.row_prev) && !(&row_i)) |=> q.key_det)
        else $error("bypass row edge missed");
    AST_EDGE_NO_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
        (!key_clock_enable_i && !q.hw_en && (&q.row_prev) && !(&row_i))
        |=> q.kp_flag ##1 (keypad_irq_o == $past(q.kd_en && q.kp_en && q.kp_flag)))
        else $error("bypass detect depends on keypad clock");
    AST_BYPASS_COLS: assert property (@(posedge clk_i) disable iff (rst_i)
        !q.hw_en |=> (col_o == $past(q.col_reg)) && (q.st == KMS_IDLE))
        else $error("bypass columns not taken from register");
    AST_ONE_COLUMN: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == KMS_SCAN) |-> ($countones(~col_o) <= 1))
        else $error("more than one column driven during scan");
    AST_FOUND_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
        found |=> (q.key_det && q.st == KMS_RELEASE && col_o == COLS_ALL_LOW
                   && q.col_reg == $past(q.col_drv)))
        else $error("found key not latched");
    AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (keypad_irq_o == $past(q.kp_flag && q.kd_en && q.kp_en)))
        else $error("keypad interrupt gating wrong");
    AST_CLOCK_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_si && !clock_event_i) |=> !q.clk_flag ##1 !clock_irq_o)
        else $error("clock flag not cleared by read");
    AST_SCAN_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == KMS_SCAN) |-> (q.slot < col_lim))
        else $error("scan slot beyond column count");

endmodule

`default_nettype wire

/* core/kms_tick.sv */
// kms_tick: keypad clock divider giving the clock level and a one-cycle millisecond enable
`default_nettype none

module kms_tick
    import kms_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = KEY_HALF_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    output logic      level_o,
    output logic      tick_o
);

    localparam int unsigned CW = $clog2(HALF_CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          level;
        logic          tick;
    } kms_tick_regs_t;

    kms_tick_regs_t q;
    kms_tick_regs_t n;

    // ------------------------------------------------------------------
    // divider: stops dead while run_i is low, keeping its level
    // ------------------------------------------------------------------
    always_comb begin
        n      = q;
        n.tick = 1'b0;
        if (run_i) begin
            if (q.cnt == CW'(HALF_CYCLES - 1)) begin
                n.cnt   = '0;
                n.level = ~q.level;
                n.tick  = ~q.level;   // one pulse per period, on the rising level
            end else begin
                n.cnt = CW'(q.cnt + 1'b1);
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level_o = q.level;
    assign tick_o  = q.tick;

endmodule

`default_nettype wire

/* inc/kms_pkg.sv */
// kms_pkg: register map, field positions, reset values and timing constants of the keypad scanner
`default_nettype none

package kms_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 10;        // core clock, 100 MHz
    localparam int unsigned KEY_CLK_PERIOD_NS = 1000000;   // keypad clock, 1 kHz
    // half period of the keypad clock in core cycles (longest time, rounds down)
    localparam int unsigned KEY_HALF_CYCLES   = KEY_CLK_PERIOD_NS / CLK_PERIOD_NS / 2;
    localparam logic [8:0]  DEBOUNCE_STEP_MS  = 9'h004;    // one debounce step
    localparam logic [8:0]  DEBOUNCE_ZERO_MS  = 9'h100;    // debounce field 0 means 256 ms
    localparam logic [8:0]  SCAN_ZERO_MS      = 9'h004;    // scan field 0 means 4 ms

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_COL_DRIVE   = 16'h00d1;
    localparam logic [15:0] IDX_ROW_SENSE   = 16'h00d2;
    localparam logic [15:0] IDX_SCAN_TIMING = 16'h00d3;
    localparam logic [15:0] IDX_CTRL_STATUS = 16'h00d4;
    localparam logic [15:0] IDX_SIZE        = 16'h00d5;
    localparam logic [15:0] IDX_ORDER_LOW   = 16'h00d6;
    localparam logic [15:0] IDX_ORDER_HIGH  = 16'h00d7;
    localparam logic [15:0] IDX_SHARED_IRQ  = 16'hff94;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CS_KD_EN    = 0;   // key_detect_irq_enable
    localparam int unsigned CS_KEY_DET  = 1;   // key_detect_flag
    localparam int unsigned CS_HW_EN    = 2;   // hw_scan_enable
    localparam int unsigned CS_CLK_LVL  = 3;   // scan_clock_level
    localparam int unsigned SI_KP_FLAG  = 0;   // keypad_irq_flag
    localparam int unsigned SI_KP_EN    = 1;   // keypad_irq_enable
    localparam int unsigned SI_CLK_FLAG = 4;   // clock_irq_flag
    localparam int unsigned SI_CLK_EN   = 5;   // clock_irq_enable
    localparam int unsigned SIZE_ROW_LSB = 3;  // row_count at 5:3
    localparam int unsigned SIZE_COL_LSB = 0;  // column_count at 2:0
    localparam int unsigned DB_LSB       = 2;  // debounce_time at 7:2
    localparam int unsigned SC_LSB       = 0;  // scan_interval at 1:0

    // ------------------------------------------------------------------
    // matrix geometry and reset values
    // ------------------------------------------------------------------
    localparam int unsigned NUM_ROWS = 6;
    localparam int unsigned NUM_COLS = 5;
    localparam logic [5:0]  ROWS_IDLE    = 6'h3f;
    localparam logic [4:0]  COLS_IDLE    = 5'h1f;
    localparam logic [4:0]  COLS_ALL_LOW = 5'h00;
    localparam logic [4:0]  RST_COL_DRIVE = 5'h1f;
    localparam logic [7:0]  RST_REG8      = 8'h00;

    // scanner states
    typedef enum logic [1:0] {
        KMS_IDLE    = 2'b00,
        KMS_PRESS   = 2'b01,
        KMS_SCAN    = 2'b10,
        KMS_RELEASE = 2'b11
    } kms_state_t;

endpackage

`default_nettype wire

/* sim/kms_keypad_tb.sv */
// kms_keypad_tb: self-checking bench for the keypad scanner
`default_nettype none
module kms_keypad_tb
    import kms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, we, cyc, stb, kclk, cev, down, ack, kirq, cirq;
    logic [15:0] adr, regs [4];
    logic [31:0] dat, dato, seed;
    logic [3:0]  sel;
    logic [4:0]  col;
    logic [5:0]  row;
    logic [7:0]  q, w, mdl [int];
    int          fails, comparisons, hi;
    // a short keypad clock keeps one millisecond at ten core cycles
    kms_keypad #(.KEY_HALF(5)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat),
        .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dato), .ack_o(ack),
        .row_i(row), .col_o(col), .key_clock_enable_i(kclk), .clock_event_i(cev),
        .keypad_irq_o(kirq), .clock_irq_o(cirq));
    kms_matrix_model pad (.col_i(col), .key_row_i(3'h3), .key_col_i(3'h2), .down_i(down),
        .row_o(row));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one classic cycle; request stands until the rising edge that samples ack high
    task automatic wb(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        adr <= a; dat <= {24'h0, d}; we <= wr; sel <= 4'h1; cyc <= 1'b1; stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            fails++;
            finish_test();
        end
        q = dato[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q & m, e);
    endtask
    task automatic irqs(input logic [1:0] e);
        repeat (2) @(negedge clk_i);
        chk({6'h0, cirq, kirq}, {6'h0, e});
        @(posedge clk_i);
    endtask
    task automatic wait_irq(input int lim);
        int n;
        for (n = 0; n < lim && kirq !== 1'b1; n++) @(negedge clk_i);
        if (n >= lim) begin
            fails++;
            finish_test();
        end
        @(posedge clk_i);
    endtask
    initial begin
        rst_i = 1'b1; we = 0; cyc = 0; stb = 0; kclk = 0; cev = 0; down = 0;
        adr = '0; dat = '0; sel = '0; seed = 32'h5514be4e;
        regs = '{IDX_SCAN_TIMING, IDX_SIZE, IDX_ORDER_LOW, IDX_ORDER_HIGH};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(IDX_COL_DRIVE, 8'hff, 8'h1f);
        chk({3'h0, col}, {3'h0, COLS_IDLE});
        rd(IDX_ROW_SENSE, 8'hff, 8'h3f);
        rd(IDX_SHARED_IRQ, 8'hff, 8'h00);
        rd(16'h00c0, 8'hff, 8'h00);
        // random contents into the plain registers, then read the model back
        for (int i = 0; i < 4; i++) begin
            w = 8'(rnd());
            if (i == 1) w &= 8'h3f;
            mdl[i] = (i == 3) ? (w & 8'h7f) : w;
            wb(1'b1, regs[i], w);
        end
        foreach (mdl[i]) rd(regs[i], 8'hff, mdl[i]);
        $display("registers test done");
        // bypass with the keypad clock stopped, detect enable clear and then set
        wb(1'b1, IDX_SHARED_IRQ, 8'h22);
        wb(1'b1, IDX_CTRL_STATUS, 8'h00);
        wb(1'b1, IDX_COL_DRIVE, 8'h00);
        down <= 1'b1;
        irqs(2'b00);
        rd(IDX_SHARED_IRQ, 8'hff, 8'h23);
        rd(IDX_SHARED_IRQ, 8'hff, 8'h22);
        rd(IDX_CTRL_STATUS, 8'hf7, 8'h02);
        rd(IDX_CTRL_STATUS, 8'hf7, 8'h00);
        down <= 1'b0;
        wb(1'b1, IDX_CTRL_STATUS, 8'h01);
        down <= 1'b1;
        wait_irq(10);
        rd(IDX_CTRL_STATUS, 8'hf7, 8'h03);
        down <= 1'b0;
        repeat (2) @(posedge clk_i);
        down <= 1'b1;
        // let the new edge land before the read that must see it
        @(posedge clk_i);
        rd(IDX_CTRL_STATUS, 8'hf7, 8'h03);
        rd(IDX_SHARED_IRQ, 8'hff, 8'h23);
        irqs(2'b00);
        down <= 1'b0;
        cev <= 1'b1;
        @(posedge clk_i);
        cev <= 1'b0;
        irqs(2'b10);
        rd(IDX_SHARED_IRQ, 8'hff, 8'h32);
        irqs(2'b00);
        $display("bypass test done");
        // hardware scan in reversed order, key at column 2 row 3
        kclk <= 1'b1;
        wb(1'b1, IDX_SCAN_TIMING, 8'h05);
        wb(1'b1, IDX_SIZE, 8'h35);
        wb(1'b1, IDX_ORDER_LOW, 8'h9c);
        wb(1'b1, IDX_ORDER_HIGH, 8'h02);
        wb(1'b1, IDX_CTRL_STATUS, 8'h05);
        down <= 1'b1;
        // 4 ms debounce plus three 1 ms slot checks cannot finish within 5 ms
        repeat (50) @(posedge clk_i);
        chk({7'h0, kirq}, 8'h00);
        wait_irq(40);
        rd(IDX_COL_DRIVE, 8'hff, 8'h1b);
        rd(IDX_ROW_SENSE, 8'hff, 8'h37);
        rd(IDX_CTRL_STATUS, 8'hf7, 8'h07);
        chk({3'h0, col}, {3'h0, COLS_ALL_LOW});
        // a key outside the programmed rows, then outside the programmed columns
        for (int i = 0; i < 2; i++) begin
            down <= 1'b0;
            repeat (150) @(posedge clk_i);
            wb(1'b0, IDX_SHARED_IRQ, 8'h00);
            // handler reloads natural order 0,1,2,3,4 before the next press
            wb(1'b1, IDX_ORDER_LOW, 8'h88);
            wb(1'b1, IDX_ORDER_HIGH, 8'h46);
            wb(1'b1, IDX_SIZE, i ? 8'h32 : 8'h1d);
            down <= 1'b1;
            repeat (400) @(posedge clk_i);
            irqs(2'b00);
        end
        hi = 0;
        repeat (20) begin
            wb(1'b0, IDX_CTRL_STATUS, 8'h00);
            hi += q[3];
        end
        chk(8'(hi > 0 && hi < 20), 8'h01);
        $display("scan test done");
        finish_test();
    end
endmodule
`default_nettype wire

/* sim/kms_matrix_model.sv */
// kms_matrix_model: passive switch matrix with pulled-up rows
`default_nettype none
module kms_matrix_model (
    input  wire logic [4:0] col_i,
    input  wire logic [2:0] key_row_i,
    input  wire logic [2:0] key_col_i,
    input  wire logic       down_i,
    output logic      [5:0] row_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // a closed switch ties its row to its column; open rows float up to the pull-up
    always_comb begin
        row_o = 6'h3f;
        if (down_i && !col_i[key_col_i]) row_o[key_row_i] = 1'b0;
    end
endmodule
`default_nettype wire
